// *** pkg/ccevs_pkg.sv ***
// Purpose: Shared constants for the capture/compare event status block
// Assumes: 32-bit classic Wishbone, byte addresses in wb_adr_i[7:0]
// Notes:   Register offsets are word aligned
package ccevs_pkg;
    localparam int NUM_CH = 4;
    localparam int TMR_W  = 16;
    // Register byte offsets
    localparam logic [7:0] ADR_PEND_LOW  = 8'h00;
    localparam logic [7:0] ADR_EN_LOW    = 8'h04;
    localparam logic [7:0] ADR_PEND_HIGH = 8'h08;
    localparam logic [7:0] ADR_EN_HIGH   = 8'h0c;
    localparam logic [7:0] ADR_OVR_EN    = 8'h10;
    localparam logic [7:0] ADR_OVR_STAT  = 8'h14;
    localparam logic [7:0] ADR_TMR_CTRL  = 8'h18;
    localparam logic [7:0] ADR_TMR1      = 8'h1c;
    localparam logic [7:0] ADR_TMR2      = 8'h20;
    localparam logic [3:0] ADR_CTRL_BLK  = 4'h4;
    localparam logic [3:0] ADR_TIME_BLK  = 4'h6;
    // Channel control fields
    localparam int CTL_TB   = 7;
    localparam int CTL_CE   = 6;
    localparam int CTL_M1   = 5;
    localparam int CTL_M0   = 4;
    localparam int CTL_RE   = 3;
    localparam int CTL_ROT  = 1;
    localparam int CTL_ONRT = 0;
    localparam logic [7:0] CTL_MASK = 8'hfb;
    // Pending fields
    localparam int PL_TMR1 = 4;
    localparam int PL_TMR2 = 5;
    localparam int PH_PAIR_A = 4;
    localparam int PH_PAIR_B = 5;
    localparam logic [7:0] PL_MASK = 8'h3f;
    localparam logic [7:0] PH_MASK = 8'h30;
    // Timer control fields
    localparam int TC_RUN1 = 0;
    localparam int TC_RUN2 = 1;
    // Reset values
    localparam logic [7:0]  RST_REG8 = 8'h00;
    localparam logic [15:0] RST_TMR  = 16'h0000;
    localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
endpackage

// *** verilog/ccevs_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ccevs_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            q_o  <= s1_r;
        end
    end
endmodule
`default_nettype wire

// *** verilog/ccevs_channel.sv ***
// Purpose: One capture/compare channel with event-time register and buffer
// Assumes: pin_i already synchronised; timers step at most once a cycle
// Notes:   Event, overrun and timer-reset outputs are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ccevs_channel
    import ccevs_pkg::*;
#(
    parameter int W = TMR_W
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [7:0]   ctrl_i,
    input  wire logic         pin_i,
    input  wire logic [W-1:0] ref_tmr_i,
    input  wire logic         time_wr_i,
    input  wire logic [W-1:0] time_wdat_i,
    input  wire logic         time_rd_i,
    output var  logic [W-1:0] time_o,
    output var  logic         event_o,
    output var  logic         overrun_o,
    output var  logic         rst_ref_o,
    output var  logic         rst_opp_o,
    output var  logic         pin_o
);
    logic [W-1:0] buf_r, time_nxt, buf_nxt;
    logic         tfull_r, bfull_r, tfull_nxt, bfull_nxt;
    logic         pin_d_r, armed_r, eq_d_r, ev_nxt, ov_nxt;
    logic         ce, cap, eq, match;

    assign ce    = ctrl_i[CTL_CE];
    assign cap   = !ce && ((ctrl_i[CTL_M0] && pin_d_r && !pin_i) || (ctrl_i[CTL_M1] && !pin_d_r && pin_i));
    assign eq    = (ref_tmr_i == time_o);
    // Edge of equality, so a stopped timer cannot retrigger
    assign match = ce && armed_r && eq && !eq_d_r;

    always_comb begin
        time_nxt  = time_o;
        buf_nxt   = buf_r;
        tfull_nxt = tfull_r;
        bfull_nxt = bfull_r;
        ev_nxt    = 1'b0;
        ov_nxt    = 1'b0;
        if (time_wr_i) begin
            time_nxt = time_wdat_i;
        end
        // RULE_17 read drains buffer
        if (time_rd_i && !ce) begin
            if (bfull_r) begin
                time_nxt  = buf_r;
                bfull_nxt = 1'b0;
                ev_nxt    = 1'b1;
            end else begin
                tfull_nxt = 1'b0;
            end
        end
        // RULE_16 store reference timer
        if (cap) begin
            if (!tfull_nxt) begin
                time_nxt  = ref_tmr_i;
                tfull_nxt = 1'b1;
                // RULE_07 pending on move
                ev_nxt    = 1'b1;
            end else if (!bfull_nxt) begin
                buf_nxt   = ref_tmr_i;
                bfull_nxt = 1'b1;
            end else begin
                // RULE_01 overrun, overwrite option
                ov_nxt = 1'b1;
                if (ctrl_i[CTL_ONRT]) begin
                    buf_nxt = ref_tmr_i;
                end
            end
        end
        if (ce) begin
            tfull_nxt = 1'b0;
            bfull_nxt = 1'b0;
        end
        // RULE_06 pending on every match
        if (match) begin
            ev_nxt = 1'b1;
        end
    end

    // RULE_18 flags clear at reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            time_o    <= '0;
            buf_r     <= '0;
            tfull_r   <= 1'b0;
            bfull_r   <= 1'b0;
            event_o   <= 1'b0;
            overrun_o <= 1'b0;
        end else begin
            time_o    <= time_nxt;
            buf_r     <= buf_nxt;
            tfull_r   <= tfull_nxt;
            bfull_r   <= bfull_nxt;
            event_o   <= ev_nxt;
            overrun_o <= ov_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_d_r <= 1'b0;
            eq_d_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            pin_d_r <= pin_i;
            eq_d_r  <= eq;
            if (time_wr_i && ce) begin
                armed_r <= 1'b1;
            end else if (match && !ctrl_i[CTL_RE]) begin
                armed_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o     <= 1'b0;
            rst_ref_o <= 1'b0;
            rst_opp_o <= 1'b0;
        end else begin
            if (match) begin
                unique case ({ctrl_i[CTL_M1], ctrl_i[CTL_M0]})
                    2'b01: pin_o <= 1'b0;
                    2'b10: pin_o <= 1'b1;
                    2'b11: pin_o <= !pin_o;
                    2'b00: pin_o <= pin_o;
                endcase
            end
            // RULE_02 reset on match
            // RULE_15 pick reference or opposite
            rst_ref_o <= match && ctrl_i[CTL_ONRT] && !ctrl_i[CTL_ROT];
            rst_opp_o <= (match && ctrl_i[CTL_ONRT] && ctrl_i[CTL_ROT]) || (cap && ctrl_i[CTL_ROT]);
        end
    end
endmodule
`default_nettype wire

// *** verilog/ccevs_top.sv ***
// Purpose: Four-channel capture/compare unit with two timers and status
// Assumes: Classic Wishbone slave, 32-bit data, one clock domain
// Notes:   Registers answer one cycle after the request is seen
// Function
// RULE_01 - Capture overrun; overwrite bit picks survivor
// RULE_02 - Compare match resets selected timer if enabled
// RULE_03 - Four channel, two overflow pending bits
// RULE_04 - Overruns grouped into high bits 4, 5
// RULE_05 - Overrun source enables gate pair bits
// RULE_06 - Compare match sets pending even masked
// RULE_07 - Capture into time register sets pending
// RULE_08 - Overflow and overrun set pending bits
// RULE_09 - Mask blocks delivery, pending still updates
// RULE_10 - Overrun status mirrors enable layout
// RULE_11 - Vectoring leaves overrun status bits alone
// RULE_12 - Vectoring clears only that pair bit
// RULE_13 - Software writes never set overrun status
// RULE_14 - Software polls status to find overrun
// RULE_15 - Timer pick: reference or opposite timer
// RULE_16 - Capture stores reference timer value
// RULE_17 - Reading time register drains the buffer
// RULE_18 - Reset clears pending, status, full flags
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccevs_top
    import ccevs_pkg::*;
#(
    parameter int NCH = NUM_CH,
    parameter int TW  = TMR_W
) (
    input  wire logic           clk_i,
    input  wire logic           resetn_i,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output var  logic [31:0]    wb_dat_o,
    output var  logic           wb_ack_o,
    input  wire logic [NCH-1:0] cap_pin_i,
    output var  logic [NCH-1:0] cmp_pin_o,
    input  wire logic [1:0]     vector_ack_i,
    output var  logic           irq_o
);
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // A select on a call result is not legal, so timer-wide merges go through here
    function automatic logic [TW-1:0] wb_merge_t(input logic [TW-1:0] old, input logic [31:0] nw,
                                                 input logic [3:0] sel);
        logic [31:0] m;
        m = wb_merge({{(32-TW){1'b0}}, old}, nw, sel);
        return m[TW-1:0];
    endfunction

    function automatic logic w1c_lo(input logic [31:0] d, input logic [3:0] sel, input int bit_n);
        return sel[0] && d[bit_n];
    endfunction

    logic        take, wr_en, rd_en;
    logic [1:0]  ch_idx;
    logic        ctrl_hit, time_hit;
    logic [31:0] rdata;

    logic [7:0]  pend_low_r, en_low_r, pend_high_r, en_high_r;
    logic [7:0]  ovr_en_r, ovr_stat_r, tmr_ctrl_r;
    logic [7:0]  pend_low_nxt, pend_high_nxt, ovr_stat_nxt;
    logic [7:0]  ctrl_r [NCH];
    logic [TW-1:0] tmr1_r, tmr2_r;
    logic        ovf1, ovf2, rst_t1, rst_t2;

    logic [NCH-1:0] pin_s, ev, ovr, rst_ref, rst_opp, t_wr, t_rd;
    logic [TW-1:0]  ch_time [NCH];
    logic [NCH-1:0] ovr_gated;

    ccevs_sync #(
        .W (NCH)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (cap_pin_i),
        .q_o      (pin_s)
    );

    // Wishbone decode: one request answered per ack
    assign take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en    = take && wb_we_i;
    assign rd_en    = take && !wb_we_i;
    assign ch_idx   = wb_adr_i[3:2];
    assign ctrl_hit = (wb_adr_i[7:4] == ADR_CTRL_BLK);
    assign time_hit = (wb_adr_i[7:4] == ADR_TIME_BLK);

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [TW-1:0] ref_t;
        logic          tb;
        assign tb    = ctrl_r[c][CTL_TB];
        assign ref_t = tb ? tmr2_r : tmr1_r;
        assign t_wr[c] = wr_en && time_hit && (ch_idx == c[1:0]) && wb_sel_i[0];
        assign t_rd[c] = rd_en && time_hit && (ch_idx == c[1:0]);

        ccevs_channel #(
            .W (TW)
        ) u_ch (
            .clk_i       (clk_i),
            .resetn_i    (resetn_i),
            .ctrl_i      (ctrl_r[c]),
            .pin_i       (pin_s[c]),
            .ref_tmr_i   (ref_t),
            .time_wr_i   (t_wr[c]),
            .time_wdat_i (wb_merge_t(ch_time[c], wb_dat_i, wb_sel_i)),
            .time_rd_i   (t_rd[c]),
            .time_o      (ch_time[c]),
            .event_o     (ev[c]),
            .overrun_o   (ovr[c]),
            .rst_ref_o   (rst_ref[c]),
            .rst_opp_o   (rst_opp[c]),
            .pin_o       (cmp_pin_o[c])
        );
    end

    // RULE_02 map channel resets to timers
    always_comb begin
        rst_t1 = 1'b0;
        rst_t2 = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            if (ctrl_r[c][CTL_TB]) begin
                rst_t2 = rst_t2 || rst_ref[c];
                rst_t1 = rst_t1 || rst_opp[c];
            end else begin
                rst_t1 = rst_t1 || rst_ref[c];
                rst_t2 = rst_t2 || rst_opp[c];
            end
        end
    end

    assign ovf1 = tmr_ctrl_r[TC_RUN1] && (tmr1_r == {TW{1'b1}});
    assign ovf2 = tmr_ctrl_r[TC_RUN2] && (tmr2_r == {TW{1'b1}});

    // Channel resets lose to a software load in the same cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tmr1_r <= RST_TMR;
            tmr2_r <= RST_TMR;
        end else begin
            if (wr_en && wb_adr_i == ADR_TMR1) begin
                tmr1_r <= wb_merge_t(tmr1_r, wb_dat_i, wb_sel_i);
            end else if (rst_t1) begin
                tmr1_r <= RST_TMR;
            end else if (tmr_ctrl_r[TC_RUN1]) begin
                tmr1_r <= tmr1_r + 1'b1;
            end
            if (wr_en && wb_adr_i == ADR_TMR2) begin
                tmr2_r <= wb_merge_t(tmr2_r, wb_dat_i, wb_sel_i);
            end else if (rst_t2) begin
                tmr2_r <= RST_TMR;
            end else if (tmr_ctrl_r[TC_RUN2]) begin
                tmr2_r <= tmr2_r + 1'b1;
            end
        end
    end

    // Plain read/write configuration
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_low_r   <= RST_REG8;
            en_high_r  <= RST_REG8;
            ovr_en_r   <= RST_REG8;
            tmr_ctrl_r <= RST_REG8;
            for (int c = 0; c < NCH; c++) begin
                ctrl_r[c] <= RST_REG8;
            end
        end else if (wr_en && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_EN_LOW) begin
                en_low_r <= wb_dat_i[7:0] & PL_MASK;
            end
            if (wb_adr_i == ADR_EN_HIGH) begin
                en_high_r <= wb_dat_i[7:0] & PH_MASK;
            end
            if (wb_adr_i == ADR_OVR_EN) begin
                ovr_en_r <= {4'h0, wb_dat_i[3:0]};
            end
            if (wb_adr_i == ADR_TMR_CTRL) begin
                tmr_ctrl_r <= {6'h00, wb_dat_i[1:0]};
            end
            if (ctrl_hit) begin
                ctrl_r[ch_idx] <= wb_dat_i[7:0] & CTL_MASK;
            end
        end
    end

    // RULE_05 per-source overrun enables
    assign ovr_gated = ovr & ovr_en_r[NCH-1:0];

    // Set always wins over a clear in the same cycle
    always_comb begin
        pend_low_nxt  = pend_low_r;
        pend_high_nxt = pend_high_r;
        ovr_stat_nxt  = ovr_stat_r;
        if (wr_en && wb_adr_i == ADR_PEND_LOW) begin
            for (int b = 0; b < 8; b++) begin
                if (w1c_lo(wb_dat_i, wb_sel_i, b)) begin
                    pend_low_nxt[b] = 1'b0;
                end
            end
        end
        if (wr_en && wb_adr_i == ADR_PEND_HIGH) begin
            for (int b = 0; b < 8; b++) begin
                if (w1c_lo(wb_dat_i, wb_sel_i, b)) begin
                    pend_high_nxt[b] = 1'b0;
                end
            end
        end
        // RULE_12 vectoring clears pair only
        if (vector_ack_i[0]) begin
            pend_high_nxt[PH_PAIR_A] = 1'b0;
        end
        if (vector_ack_i[1]) begin
            pend_high_nxt[PH_PAIR_B] = 1'b0;
        end
        // RULE_11 status untouched by vectoring
        // RULE_13 writes only clear status
        if (wr_en && wb_adr_i == ADR_OVR_STAT) begin
            for (int b = 0; b < NCH; b++) begin
                if (w1c_lo(wb_dat_i, wb_sel_i, b)) begin
                    ovr_stat_nxt[b] = 1'b0;
                end
            end
        end
        // RULE_03 channel and overflow bits
        // RULE_06 events set pending regardless
        pend_low_nxt[NCH-1:0] = pend_low_nxt[NCH-1:0] | ev;
        // RULE_08 overflow sets pending
        if (ovf1) begin
            pend_low_nxt[PL_TMR1] = 1'b1;
        end
        if (ovf2) begin
            pend_low_nxt[PL_TMR2] = 1'b1;
        end
        // RULE_04 pairs into high bits
        if (|ovr_gated[1:0]) begin
            pend_high_nxt[PH_PAIR_A] = 1'b1;
        end
        if (|ovr_gated[3:2]) begin
            pend_high_nxt[PH_PAIR_B] = 1'b1;
        end
        // RULE_10 one status bit per channel
        ovr_stat_nxt[NCH-1:0] = ovr_stat_nxt[NCH-1:0] | ovr;
    end

    // RULE_18 pending and status reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_low_r  <= RST_REG8;
            pend_high_r <= RST_REG8;
            ovr_stat_r  <= RST_REG8;
        end else begin
            pend_low_r  <= pend_low_nxt & PL_MASK;
            pend_high_r <= pend_high_nxt & PH_MASK;
            ovr_stat_r  <= ovr_stat_nxt;
        end
    end

    // RULE_14 status readable for polling
    always_comb begin
        rdata = RD_ZERO;
        if (ctrl_hit) begin
            rdata[7:0] = ctrl_r[ch_idx];
        end else if (time_hit) begin
            rdata[TW-1:0] = ch_time[ch_idx];
        end else begin
            unique case (wb_adr_i)
                ADR_PEND_LOW:  rdata[7:0] = pend_low_r;
                ADR_EN_LOW:    rdata[7:0] = en_low_r;
                ADR_PEND_HIGH: rdata[7:0] = pend_high_r;
                ADR_EN_HIGH:   rdata[7:0] = en_high_r;
                ADR_OVR_EN:    rdata[7:0] = ovr_en_r;
                ADR_OVR_STAT:  rdata[7:0] = ovr_stat_r;
                ADR_TMR_CTRL:  rdata[7:0] = tmr_ctrl_r;
                ADR_TMR1:      rdata[TW-1:0] = tmr1_r;
                ADR_TMR2:      rdata[TW-1:0] = tmr2_r;
                default:       rdata = RD_ZERO;
            endcase
        end
    end

    // Ack every request, unmapped ones read zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RD_ZERO;
        end else begin
            wb_ack_o <= take;
            if (rd_en) begin
                wb_dat_o <= rdata;
            end
        end
    end

    // RULE_09 mask gates only delivery
    assign irq_o = |(pend_low_r & en_low_r) || |(pend_high_r & en_high_r);
endmodule
`default_nettype wire

// *** tb/ccevs_chk.sv ***
// Purpose: Port-level checks of the capture/compare status block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to ccevs_top below
`timescale 1ns/1ps
`default_nettype none
module ccevs_chk
    import ccevs_pkg::*;
#(
    parameter int NCH = NUM_CH,
    parameter int TW  = TMR_W
) (
    input wire logic           clk_i,
    input wire logic           resetn_i,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_we_i,
    input wire logic [7:0]     wb_adr_i,
    input wire logic [3:0]     wb_sel_i,
    input wire logic [31:0]    wb_dat_i,
    input wire logic [31:0]    wb_dat_o,
    input wire logic           wb_ack_o,
    input wire logic [NCH-1:0] cap_pin_i,
    input wire logic [NCH-1:0] cmp_pin_o,
    input wire logic [1:0]     vector_ack_i,
    input wire logic           irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic rd_take;
    assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (rd_take && wb_adr_i == 8'h24 |=> wb_dat_o == RD_ZERO)
        else $error("unmapped read not zero");
    pend_low_bits_a: assert property (rd_take && wb_adr_i == ADR_PEND_LOW |=> wb_dat_o[31:6] == '0)
        else $error("pending low has extra bits");
    pair_bits_only_a: assert property (rd_take && wb_adr_i == ADR_PEND_HIGH ##1 wb_ack_o |-> (wb_dat_o[7:0] & ~PH_MASK) == 8'h00 && wb_dat_o[31:8] == '0)
        else $error("pending high outside pair bits");
    stat_layout_a: assert property (rd_take && wb_adr_i == ADR_OVR_STAT |=> wb_dat_o[31:4] == '0)
        else $error("overrun status wider than enables");
    reset_irq_low_a: assert property ($rose(resetn_i) |-> !irq_o && cmp_pin_o == '0)
        else $error("irq or pin set after reset");
endmodule
bind ccevs_top ccevs_chk #(.NCH(NCH), .TW(TW)) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_pin_i(cap_pin_i), .cmp_pin_o(cmp_pin_o),
    .vector_ack_i(vector_ack_i), .irq_o(irq_o));
`default_nettype wire

// *** tb/ccevs_intc_model.sv ***
// Purpose: Interrupt controller stand-in issuing vector pulses
// Assumes: take_i is a one-cycle request from the software side
// Notes:   Vectors only while the block's irq line is high
`timescale 1ns/1ps
`default_nettype none
module ccevs_intc_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       irq_i,
    input  wire logic [1:0] take_i,
    output var  logic [1:0] vector_ack_o
);
    // vector only, no source
    // The pulse names the pair; which channel overran is left to polling software
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vector_ack_o <= 2'h0;
        end else begin
            vector_ack_o <= (irq_i && vector_ack_o == 2'h0) ? take_i : 2'h0;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench of the capture/compare status block
// Assumes: One-cycle Wishbone answer, pins synchronised inside
// Notes:   Timers are stopped while captures run so times are known
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccevs_pkg::*;
    logic        clk_i, resetn_i;
    logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0, cap_pin_i = 4'h0, cmp_pin_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [1:0]  take = 2'h0, vector_ack_i;
    int          n_fail = 0, n_compared = 0;

    ccevs_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_pin_i(cap_pin_i), .cmp_pin_o(cmp_pin_o),
        .vector_ack_i(vector_ack_i), .irq_o(irq_o));
    ccevs_intc_model u_intc (.clk_i(clk_i), .resetn_i(resetn_i), .irq_i(irq_o), .take_i(take),
        .vector_ack_o(vector_ack_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Request held until ack is sampled high, then released
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "no ack");
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string m);
        wb(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask

    task automatic t_reset_vals;
        rc(ADR_PEND_LOW, RD_ZERO, "pend low reset");
        rc(ADR_PEND_HIGH, RD_ZERO, "pend high reset");
        rc(ADR_OVR_STAT, RD_ZERO, "status reset");
        rc(8'h24, RD_ZERO, "unmapped read");
        chk(irq_o, 1'b0, "irq after reset");
    endtask

    // Both channels match timer 1 at 0x40; without resets both timers would pass 0x60
    task automatic t_compare;
        wb(1'b1, ADR_TMR1, 32'h0);
        wb(1'b1, ADR_TMR2, 32'h0);
        wb(1'b1, ADR_EN_LOW, 32'h0);
        wb(1'b1, 8'h40, 32'h61);
        wb(1'b1, 8'h60, 32'h40);
        wb(1'b1, 8'h44, 32'h53);
        wb(1'b1, 8'h64, 32'h40);
        wb(1'b1, ADR_TMR_CTRL, 32'h3);
        repeat (100) @(posedge clk_i);
        wb(1'b1, ADR_TMR_CTRL, 32'h0);
        wb(1'b0, ADR_TMR1, 32'h0);
        chk(32'(q < 32'h40), 32'h1, "timer1 not reset");
        wb(1'b0, ADR_TMR2, 32'h0);
        chk(32'(q < 32'h40), 32'h1, "timer2 not reset");
        chk(cmp_pin_o[1:0], 2'b01, "compare pins");
        wb(1'b0, ADR_PEND_LOW, 32'h0);
        chk(q[1:0], 2'b11, "masked match pending");
        chk(irq_o, 1'b0, "masked irq");
        wb(1'b1, ADR_EN_LOW, 32'h1);
        chk(irq_o, 1'b1, "unmasked irq");
        wb(1'b1, ADR_PEND_LOW, 32'h3);
        chk(irq_o, 1'b0, "irq after clear");
        wb(1'b1, ADR_EN_LOW, 32'h0);
    endtask

    task automatic t_capture;
        logic [15:0] tv [3];
        tv = '{16'h0011, 16'h0022, 16'h0033};
        wb(1'b1, 8'h40, 32'h0);
        wb(1'b1, 8'h44, 32'h20);
        wb(1'b1, 8'h48, 32'h21);
        wb(1'b1, ADR_OVR_EN, 32'h4);
        foreach (tv[i]) begin
            wb(1'b1, ADR_TMR1, 32'(tv[i]));
            @(posedge clk_i);
            cap_pin_i <= 4'h6;
            repeat (8) @(posedge clk_i);
            cap_pin_i <= 4'h0;
            repeat (8) @(posedge clk_i);
        end
        rc(ADR_OVR_STAT, 32'h6, "overrun status");
        rc(ADR_PEND_HIGH, 32'h20, "pair bits gated");
        wb(1'b0, ADR_PEND_LOW, 32'h0);
        chk(q[2:1], 2'b11, "capture pending");
        wb(1'b1, ADR_EN_HIGH, 32'h20);
        chk(irq_o, 1'b1, "pair B irq");
        rc(8'h64, 32'h11, "ch1 first time");
        rc(8'h64, 32'h22, "ch1 new data ignored");
        rc(8'h68, 32'h11, "ch2 first time");
        rc(8'h68, 32'h33, "ch2 old data overwritten");
        @(posedge clk_i);
        take <= 2'b10;
        @(posedge clk_i);
        take <= 2'b00;
        repeat (3) @(posedge clk_i);
        rc(ADR_PEND_HIGH, 32'h0, "vector clears pair");
        rc(ADR_OVR_STAT, 32'h6, "vector keeps status");
        chk(irq_o, 1'b0, "irq after vector");
        wb(1'b1, ADR_OVR_STAT, 32'h6);
        rc(ADR_OVR_STAT, 32'h0, "software clears status");
        wb(1'b1, ADR_OVR_STAT, 32'hf);
        rc(ADR_OVR_STAT, 32'h0, "write one never sets");
        rc(ADR_PEND_HIGH, 32'h0, "no pair from write");
        chk(irq_o, 1'b0, "no irq from write");
    endtask

    task automatic t_overflow;
        wb(1'b1, ADR_EN_HIGH, 32'h0);
        wb(1'b1, ADR_PEND_LOW, 32'h3f);
        wb(1'b1, ADR_TMR2, 32'hfffe);
        wb(1'b1, ADR_TMR_CTRL, 32'h2);
        repeat (10) @(posedge clk_i);
        wb(1'b1, ADR_TMR_CTRL, 32'h0);
        wb(1'b0, ADR_PEND_LOW, 32'h0);
        chk(q[PL_TMR2], 1'b1, "timer2 overflow pending");
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end

    initial begin
        resetn_i = 1'b0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset_vals();
        t_compare();
        t_capture();
        t_overflow();
        finish_test();
    end
endmodule
`default_nettype wire
